// *** logic/pin_share_pkg.sv ***
// constants used by the pin-sharing arbiter; its round-robin picker takes none of them
// assumes one clock and an active-low asynchronous reset everywhere

package pin_share_pkg;

  // ------------------------------------------------------------------
  // sizes of the shared conduit
  // ------------------------------------------------------------------
  localparam int CTRL_COUNT = 2;   // controllers on the arbiter
  localparam int ADDR_W     = 18;  // shared address, output pin type
  localparam int CTL_W      = 2;   // shared strobes, tri-state outputs
  localparam int DATA_W     = 8;   // shared data, bidirectional

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic OUTEN_OFF  = 1'h1;  // active-low enable released
  localparam int   PRIO_RESET = 0;     // first controller in line

  // ------------------------------------------------------------------
  // arbiter states
  // ------------------------------------------------------------------
  typedef enum logic [0:0]
  {
    ARB_IDLE  = 1'h0,   // nobody owns the pins
    ARB_OWNED = 1'h1    // one controller owns the pins
  } arb_state_type;

endpackage

// *** logic/rr_picker.sv ***
// round-robin search: first requester at or after a start index
// assumes the caller registers the result; purely combinational

module rr_picker
#(
  parameter int WIDTH = 2,   // number of request lines
  parameter int IDX_W = 1    // width of an index
)
(
  input  wire logic [WIDTH-1:0] i_req,    // request vector
  input  wire logic [IDX_W-1:0] i_start,  // highest-priority index
  output logic                  o_found,  // some request is set
  output logic [IDX_W-1:0]      o_index   // chosen requester
);

  // ------------------------------------------------------------------
  // rotate from the start index and take the first set bit
  // ------------------------------------------------------------------
  always_comb
  begin
    int pos;
    pos     = 0;
    o_found = 1'h0;
    o_index = i_start;
    for (int k = 0; k < WIDTH; k++)
    begin
      pos = (int'(i_start) + k) % WIDTH;
      if (!o_found && i_req[pos])
      begin
        o_found = 1'h1;
        o_index = IDX_W'(pos);
      end
    end
  end

endmodule

// *** logic/shared_pin_arbiter.sv ***
// pin-sharing arbiter: several conduit controllers, one downstream conduit
// assumes synchronous inputs, one clock, downstream feeds a pad bridge
// or one controller port of another identical arbiter
//
// Function
// - during reset every output enable on the shared pins is released
// - each controller has its own request input and grant output
// - competing requests are granted in round-robin order
// - request with grant low asks for the pins this cycle
// - request with grant high asks to keep pins next cycle
// - request may return right after a transfer; rearbitrate or keep
// - grant stays high until one cycle after request drops
// - with no requests for two cycles nobody is granted; no default owner
// - owner drives or samples valid data in its first granted cycle
// - downstream conduit can feed another arbiter in a hierarchy
// - narrower shared signals align at bit zero, upper bits zero
// - unshared signals pass straight through without arbitration
// - pins encoded as value, enable and input signals by pin type
// - controller count is a build-time parameter

module shared_pin_arbiter
#(
  parameter int CONTROLLER_PORT_COUNT = pin_share_pkg::CTRL_COUNT,
  parameter int ADDR_USED [CONTROLLER_PORT_COUNT] =
    '{default: pin_share_pkg::ADDR_W},
  parameter int DATA_USED [CONTROLLER_PORT_COUNT] =
    '{default: pin_share_pkg::DATA_W}
)
(
  input  wire logic                       I_CLK,    // system clock
  input  wire logic                       I_RST_B,  // async reset, low
  // per-controller handshake
  input  wire logic [CONTROLLER_PORT_COUNT-1:0] I_REQ,  // requests
  output logic [CONTROLLER_PORT_COUNT-1:0]      O_GNT,  // grants
  // per-controller shared conduit
  input  wire logic [CONTROLLER_PORT_COUNT-1:0]
                    [pin_share_pkg::ADDR_W-1:0] I_ADDR_OUT,    // address
  input  wire logic [CONTROLLER_PORT_COUNT-1:0]
                    [pin_share_pkg::CTL_W-1:0]  I_CTL_OUT,     // strobes
  input  wire logic [CONTROLLER_PORT_COUNT-1:0] I_CTL_OUTEN_B, // strobe oe
  input  wire logic [CONTROLLER_PORT_COUNT-1:0]
                    [pin_share_pkg::DATA_W-1:0] I_DATA_OUT,    // data out
  input  wire logic [CONTROLLER_PORT_COUNT-1:0] I_DATA_OUTEN_B,// data oe
  output logic [pin_share_pkg::DATA_W-1:0]      O_DATA_IN,     // data in
  // per-controller unshared signals
  input  wire logic [CONTROLLER_PORT_COUNT-1:0] I_CS_N,  // selects down
  output logic [CONTROLLER_PORT_COUNT-1:0]      O_CS_N,  // selects out
  input  wire logic [CONTROLLER_PORT_COUNT-1:0] I_IRQ,   // pad irqs in
  output logic [CONTROLLER_PORT_COUNT-1:0]      O_IRQ,   // irqs to ctrl
  // downstream conduit
  output logic                              O_UP_REQ,       // request
  input  wire logic                         I_UP_GNT,       // grant
  output logic [pin_share_pkg::ADDR_W-1:0]  O_ADDR_OUT,     // address
  output logic [pin_share_pkg::CTL_W-1:0]   O_CTL_OUT,      // strobes
  output logic                              O_CTL_OUTEN_B,  // strobe oe
  output logic [pin_share_pkg::DATA_W-1:0]  O_DATA_OUT,     // data out
  output logic                              O_DATA_OUTEN_B, // data oe
  input  wire logic [pin_share_pkg::DATA_W-1:0] I_DATA_IN   // data in
);

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int N     = CONTROLLER_PORT_COUNT;
  localparam int IDX_W = (N > 1) ? $clog2(N) : 1;
  localparam int AW    = pin_share_pkg::ADDR_W;
  localparam int DW    = pin_share_pkg::DATA_W;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  pin_share_pkg::arb_state_type state_r;
  pin_share_pkg::arb_state_type state_nxt;
  logic [IDX_W-1:0]             owner_r;
  logic [IDX_W-1:0]             owner_nxt;
  logic [IDX_W-1:0]             prio_r;
  logic [IDX_W-1:0]             prio_nxt;

  // ------------------------------------------------------------------
  // decode of the present ownership
  // ------------------------------------------------------------------
  wire              owned      = (state_r == pin_share_pkg::ARB_OWNED);
  wire              owner_req  = I_REQ[owner_r];
  wire              keep       = owned && owner_req;
  wire              ending     = owned && !owner_req;
  wire              live       = owned && I_UP_GNT;
  wire [IDX_W-1:0]  owner_next = (owner_r == IDX_W'(N - 1)) ?
                                 '0 : owner_r + IDX_W'(1);
  wire [IDX_W-1:0]  start_idx  = ending ? owner_next : prio_r;
  wire              pick_found;
  wire [IDX_W-1:0]  pick_index;

  // ------------------------------------------------------------------
  // round-robin choice among waiting controllers
  // ------------------------------------------------------------------
  rr_picker
  #(
    .WIDTH (N),
    .IDX_W (IDX_W)
  )
  u_picker
  (
    .i_req   (I_REQ),
    .i_start (start_idx),
    .o_found (pick_found),
    .o_index (pick_index)
  );

  // ------------------------------------------------------------------
  // next ownership: keep, hand over, or go idle
  // ------------------------------------------------------------------
  assign state_nxt = (keep || pick_found) ?
                     pin_share_pkg::ARB_OWNED :
                     pin_share_pkg::ARB_IDLE;
  assign owner_nxt = keep       ? owner_r :
                     pick_found ? pick_index :
                     owner_r;
  assign prio_nxt  = ending ? owner_next : prio_r;

  // ------------------------------------------------------------------
  // arbitration registers
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state_r <= pin_share_pkg::ARB_IDLE;
      owner_r <= '0;
      prio_r  <= IDX_W'(pin_share_pkg::PRIO_RESET);
    end
    else
    begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
      prio_r  <= prio_nxt;
    end
  end

  // ------------------------------------------------------------------
  // per-controller grant, width alignment and pass-through
  // ------------------------------------------------------------------
  logic [N-1:0][AW-1:0] addr_m;
  logic [N-1:0][DW-1:0] data_m;

  for (genvar g = 0; g < N; g++)
  begin : g_ctrl
    localparam logic [AW-1:0] AMASK = {AW{1'h1}} >> (AW - ADDR_USED[g]);
    localparam logic [DW-1:0] DMASK = {DW{1'h1}} >> (DW - DATA_USED[g]);
    // grant seen only when the upstream side also grants
    assign O_GNT[g]  = live && (owner_r == IDX_W'(g));
    assign addr_m[g] = I_ADDR_OUT[g] & AMASK;
    assign data_m[g] = I_DATA_OUT[g] & DMASK;
  end

  // unshared signals bypass the arbiter
  assign O_CS_N = I_CS_N;
  assign O_IRQ  = I_IRQ;

  // ------------------------------------------------------------------
  // downstream conduit: owner's values, enables gated by reset
  // ------------------------------------------------------------------
  wire drive_ok = I_RST_B && live;

  assign O_ADDR_OUT     = live ? addr_m[owner_r] : '0;
  assign O_CTL_OUT      = live ? I_CTL_OUT[owner_r] : '0;
  assign O_DATA_OUT     = live ? data_m[owner_r] : '0;
  assign O_CTL_OUTEN_B  = drive_ok ? I_CTL_OUTEN_B[owner_r] :
                          pin_share_pkg::OUTEN_OFF;
  assign O_DATA_OUTEN_B = drive_ok ? I_DATA_OUTEN_B[owner_r] :
                          pin_share_pkg::OUTEN_OFF;
  assign O_DATA_IN      = I_DATA_IN;

  // upstream request mirrors the owner, or any waiter when idle
  assign O_UP_REQ = owned ? owner_req : (|I_REQ);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_reset_outen_off : assert property (
    @(posedge I_CLK) disable iff (1'h0)
    !I_RST_B |-> (O_DATA_OUTEN_B && O_CTL_OUTEN_B))
    else $error("output enable active during reset");

  a_grant_one_hot : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    $onehot0(O_GNT))
    else $error("more than one grant");

  a_turn_passes : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ending && ((I_REQ & ~(N'(1) << owner_r)) != '0))
    |=> (owned && (owner_r != $past(owner_r))))
    else $error("round-robin did not move to another requester");

  a_idle_takes_req : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (!owned && (|I_REQ)) |=> owned)
    else $error("idle request not taken next cycle");

  a_owner_kept : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    keep |=> (owned && $stable(owner_r)))
    else $error("owner lost pins while still requesting");

  a_reraise_back : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ending && (I_REQ == '0)) ##1 (I_REQ == (N'(1) << $past(owner_r)))
    |=> (owned && (owner_r == $past(owner_r, 2))))
    else $error("lone re-request not granted back");

  a_idle_no_grant : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ == '0) [*2] |-> (O_GNT == '0))
    else $error("grant with no requester");

  a_up_req_idle : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    !owned |-> (O_UP_REQ == (|I_REQ)))
    else $error("upstream request not following waiters");

  a_pass_through : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (O_CS_N == I_CS_N) && (O_IRQ == I_IRQ) && (O_DATA_IN == I_DATA_IN))
    else $error("unshared or input signal altered");

  a_prio_advance : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    ending |=> (prio_r == $past(owner_next)))
    else $error("priority pointer not past ended owner");

  a_prio_start : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(I_RST_B) |-> (prio_r == '0))
    else $error("priority pointer not zero after reset");

  for (genvar c = 0; c < N; c++)
  begin : g_chk
    a_grant_drop : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      (O_GNT[c] && !I_REQ[c]) |=> !O_GNT[c])
      else $error("grant held past request drop");

    a_grant_cause : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      $rose(O_GNT[c]) |-> ($past(I_REQ[c]) || I_REQ[c]))
      else $error("grant without request");

    a_route_data : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_GNT[c] |-> ((O_DATA_OUT == data_m[c]) &&
                    (O_DATA_OUTEN_B == I_DATA_OUTEN_B[c]) &&
                    (O_CTL_OUT == I_CTL_OUT[c])))
      else $error("owner data not on downstream conduit");

    // bits above the owner's width must read zero
    a_upper_zero : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_GNT[c] |-> (((O_ADDR_OUT >> ADDR_USED[c]) == '0) &&
                    (((O_ADDR_OUT ^ I_ADDR_OUT[c]) << (AW - ADDR_USED[c]))
                     == '0)))
      else $error("address not aligned or upper bits not zero");

    a_route_strobe_oe : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_GNT[c] |-> (O_CTL_OUTEN_B == I_CTL_OUTEN_B[c]))
      else $error("owner strobe enable not on downstream conduit");

    a_grant_held : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      (O_GNT[c] && I_REQ[c]) |=> (O_GNT[c] || !I_UP_GNT))
      else $error("grant dropped while request still high");

    a_up_req_owner : assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_GNT[c] |-> (O_UP_REQ == I_REQ[c]))
      else $error("upstream request not following the owner");
  end

  a_no_drive_idle : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    !live |-> (O_DATA_OUTEN_B && O_CTL_OUTEN_B && (O_ADDR_OUT == '0)))
    else $error("downstream driven without an owner");

  a_idle_data_zero : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    !live |-> ((O_DATA_OUT == '0) && (O_CTL_OUT == '0)))
    else $error("downstream values not zero without an owner");

  a_handover_gapless : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (ending && (I_REQ != '0)) |=> owned)
    else $error("waiting controller not handed the pins at once");

  a_no_stray_grant : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    ((O_GNT == '0) && (I_REQ == '0)) |=> (O_GNT == '0))
    else $error("grant raised with nobody requesting");

  a_prio_hold : assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    !ending |=> $stable(prio_r))
    else $error("priority pointer moved without an ended grant");

endmodule

// *** verification/ctrl_model.sv ***
// stand-in for one conduit controller on the arbiter
// assumes the arbiter's grant and a start level from the bench
module ctrl_model
#(
  parameter logic [17:0] ADDR = 18'h0_0000,  // address it drives
  parameter logic [7:0]  DATA  = 8'h00,      // data it drives
  parameter logic [1:0]  CTL   = 2'h0,       // strobes it drives
  parameter logic        WRITE = 1'h1        // drives data when granted
)
(
  input  wire logic       i_clk,    // system clock
  input  wire logic       i_rst_b,  // async reset, low
  input  wire logic       i_go,     // start an access
  input  wire logic [3:0] i_len,    // granted cycles wanted, 2 or more
  input  wire logic       i_gnt,    // grant from arbiter
  output logic            o_req,    // request to arbiter
  output logic [17:0]     o_addr,   // address out
  output logic [1:0]      o_ctl,    // strobes out
  output logic            o_oen_b,  // strobe enable, low drives
  output logic            o_doen_b, // data enable, low drives
  output logic [7:0]      o_data    // data out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;  // granted cycles so far

  // drive from the first granted cycle on
  // idle values differ, so a wrong selection shows downstream
  assign o_oen_b  = ~i_gnt;
  assign o_doen_b = ~(i_gnt && WRITE);
  assign o_addr   = i_gnt ? ADDR : ~ADDR;
  assign o_ctl    = i_gnt ? CTL : ~CTL;
  assign o_data   = i_gnt ? DATA : ~DATA;

  // hold request until granted, drop it in the last cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      o_req <= 1'h0;
      cnt_r <= 4'h0;
    end
    else if (!o_req)
    begin
      o_req <= i_go;
      cnt_r <= 4'h0;
    end
    else if (i_gnt)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r + 4'h1 >= i_len - 4'h1)
        o_req <= 1'h0;
    end
endmodule

// *** verification/shared_pin_round_robin_arbiter_bench.sv ***
// bench for the pin-sharing arbiter with two controller models
// assumes top of hierarchy; bench plays the downstream bridge
module shared_pin_round_robin_arbiter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rst_b, up_gnt, up_req, c_oen, d_oen;
  logic [1:0]       go, req, gnt, oen_b, cs_n, irq, o_cs_n, o_irq, c_out;
  logic [1:0]       doen_b;
  logic [1:0][17:0] addr;
  logic [1:0][1:0]  ctl;
  logic [1:0][7:0]  data;
  logic [7:0]       data_in, d_in_o, d_out;
  logic [17:0]      a_out;
  logic [3:0]       len [2];
  int               n_mismatch = 0;
  int               compares = 0;

  shared_pin_arbiter
  #(
    .CONTROLLER_PORT_COUNT(2),
    .ADDR_USED('{18, 10}),
    .DATA_USED('{8, 6})
  )
  i_dut
  (
    .I_CLK(clk), .I_RST_B(rst_b), .I_REQ(req), .O_GNT(gnt),
    .I_ADDR_OUT(addr), .I_CTL_OUT(ctl), .I_CTL_OUTEN_B(oen_b),
    .I_DATA_OUT(data), .I_DATA_OUTEN_B(doen_b), .O_DATA_IN(d_in_o),
    .I_CS_N(cs_n), .O_CS_N(o_cs_n), .I_IRQ(irq), .O_IRQ(o_irq),
    .O_UP_REQ(up_req), .I_UP_GNT(up_gnt), .O_ADDR_OUT(a_out),
    .O_CTL_OUT(c_out), .O_CTL_OUTEN_B(c_oen), .O_DATA_OUT(d_out),
    .O_DATA_OUTEN_B(d_oen), .I_DATA_IN(data_in)
  );

  ctrl_model #(.ADDR(18'h2_A5C3), .DATA(8'hA5), .CTL(2'h1)) i_ctrl0
  (.i_clk(clk), .i_rst_b(rst_b), .i_go(go[0]), .i_len(len[0]),
   .i_gnt(gnt[0]), .o_req(req[0]), .o_addr(addr[0]), .o_ctl(ctl[0]),
   .o_oen_b(oen_b[0]), .o_doen_b(doen_b[0]), .o_data(data[0]));
  ctrl_model #(.ADDR(18'h3_FFFF), .DATA(8'hFC), .CTL(2'h2),
               .WRITE(1'h0)) i_ctrl1
  (.i_clk(clk), .i_rst_b(rst_b), .i_go(go[1]), .i_len(len[1]),
   .i_gnt(gnt[1]), .o_req(req[1]), .o_addr(addr[1]), .o_ctl(ctl[1]),
   .o_oen_b(oen_b[1]), .o_doen_b(doen_b[1]), .o_data(data[1]));

  // free-running clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // compare helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // routed conduit against the expected owner, -1 for nobody
  task automatic check_owner(input int who);
    logic [17:0] ea;
    logic [7:0]  ed;
    logic [1:0]  ec;
    ea = (who == 0) ? 18'h2_A5C3 : (who == 1) ? 18'h0_03FF : 18'h0_0000;
    ed = (who == 0) ? 8'hA5 : (who == 1) ? 8'h3C : 8'h00;
    ec = (who == 0) ? 2'h1 : (who == 1) ? 2'h2 : 2'h0;
    check_val(gnt, (who < 0) ? 0 : 1 << who, "grant");
    check_val(a_out, ea, "address");
    check_val(d_out, ed, "data");
    check_val(c_out, ec, "strobes");
    check_val(d_oen, who != 0, "data enable");
    check_val(c_oen, who < 0, "strobe enable");
  endtask

  // start requests, then compare one owner per cycle
  task automatic run_seq(input int h0, input int h1, input int l0,
                         input int l1, input int exp[$]);
    @(posedge clk);
    go <= {h1 > 0, h0 > 0};
    len[0] <= 4'(l0);
    len[1] <= 4'(l1);
    foreach (exp[t])
    begin
      @(posedge clk);
      go <= {t + 1 < h1, t + 1 < h0};
      @(negedge clk);
      check_owner(exp[t]);
    end
  endtask

  task automatic wait_gnt(input logic [1:0] v);
    int k;
    k = 0;
    while (gnt !== v && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    if (gnt !== v)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic pulse_reset();
    @(posedge clk);
    rst_b <= 1'h0;
    @(negedge clk);
    check_owner(-1);
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_upmask();
    @(posedge clk);
    up_gnt <= 1'h0;
    run_seq(1, 0, 2, 0, '{-1, -1, -1});
    check_val(up_req, 1, "up request");
    @(posedge clk);
    up_gnt <= 1'h1;
    wait_gnt(2'h1);
    check_owner(0);
    wait_gnt(2'h0);
    check_owner(-1);
    check_val(up_req, 0, "up request");
  endtask

  task automatic sc_wires();
    @(posedge clk);
    cs_n <= 2'h2;
    irq <= 2'h1;
    data_in <= 8'h5A;
    @(negedge clk);
    check_val(o_cs_n, 2'h2, "select");
    check_val(o_irq, 2'h1, "irq");
    check_val(d_in_o, 8'h5A, "data in");
  endtask

  initial
  begin
    rst_b = 1'h0;
    up_gnt = 1'h1;
    go = 2'h0;
    cs_n = 2'h3;
    irq = 2'h0;
    data_in = 8'h00;
    len[0] = 4'h2;
    len[1] = 4'h2;
    @(negedge clk);
    check_owner(-1);
    @(posedge clk);
    rst_b <= 1'h1;
    run_seq(1, 0, 3, 2, '{-1, 0, 0, 0, -1});
    run_seq(1, 1, 2, 2, '{-1, 1, 1, 0, 0, -1});
    run_seq(4, 0, 2, 2, '{-1, 0, 0, -1, 0, 0, -1});
    sc_upmask();
    sc_wires();
    run_seq(1, 0, 8, 2, '{-1, 0, 0});
    pulse_reset();
    run_seq(1, 1, 2, 2, '{-1, 0, 0, 1, 1, -1});
    summarize();
  end
endmodule
